// ---- common/irq_flags_consts.vh ----
// register offsets, field positions and reset values for the flag block
// assumes inclusion by bare name from rtl files
`ifndef IRQ_FLAGS_CONSTS_VH
`define IRQ_FLAGS_CONSTS_VH
// register offsets
`define ADDR_AUX_IRQ_FLAGS 8'h05
`define ADDR_CMD_ERROR_FLAGS 8'h06
`define ADDR_IRQ_ENABLE 8'h03
`define ADDR_RX_CONFIG 8'h10
`define ADDR_STATUS_OUT 8'h11
// aux flag register fields
`define AUX_SET_CLEAR_BIT 7
`define AUX_EDGE_BIT 4
`define AUX_CRC_BIT 2
// error register fields
`define ERR_WRITE_MISUSE_BIT 7
`define ERR_OVERHEAT_BIT 6
`define ERR_OVERFLOW_BIT 4
`define ERR_COLLISION_BIT 3
`define ERR_CRC_BIT 2
`define ERR_PARITY_BIT 1
`define ERR_FRAME_START_BIT 0
// rx config fields
`define CFG_RX_CRC_EN_BIT 0
`define CFG_RATE_LSB 1
// rate code 0 is 106 kBd
`define RATE_106 2'h0
// reset values
`define AUX_RESET 8'h00
`define ERR_RESET 8'h00
`define IEN_RESET 8'h00
`define CFG_RESET 8'h00
`endif

// ---- rtl/edge_sync.v ----
// two-flop synchroniser plus any-edge detector for a pin input
// assumes one clock ref_clk, asynchronous active-low reset
`timescale 1ns/1ps
module edge_sync (
   input wire ref_clk,
   input wire nrst,
   input wire pinIn,
   output reg edgePulse
);
   reg meta_q;
   reg sync_q;
   reg last_q;
   // first flop read only by the second one
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
         edgePulse <= 1'b0;
      end else begin
         meta_q <= pinIn;
         sync_q <= meta_q;
         last_q <= sync_q;
         edgePulse <= sync_q ^ last_q;
      end
   end
endmodule // edge_sync

// ---- rtl/sticky_flag.v ----
// one sticky flag: hardware set, software set or clear, set wins
// assumes same-clock pulse inputs
`timescale 1ns/1ps
module sticky_flag (
   input wire ref_clk,
   input wire nrst,
   input wire hwSet,
   input wire hwClr,
   input wire swSet,
   input wire swClr,
   output reg flag
);
   // hardware event beats any clear in the same cycle
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         flag <= 1'b0;
      end else if (hwSet || swSet) begin
         flag <= 1'b1;
      end else if (hwClr || swClr) begin
         flag <= 1'b0;
      end
   end
endmodule // sticky_flag

// ---- rtl/irq_and_error_flags.v ----
// secondary interrupt flags and command error flags of the reader front end
// assumes a same-clock register port, event pulses from same-clock logic,
// and the aux serial input arriving asynchronously from a pin
//
// Behaviour
// - write with bit 7 high sets marked flags, low clears them
// - aux flags stay latched until software clears them
// - any edge on aux serial input sets bit 4
// - crc compute done while crc compute active sets bit 2
// - after reset low four aux bits read zero
// - host fifo write during auth or rf turnaround sets bit 7
// - overheat sets bit 6 and switches antenna drivers off
// - fifo write while full sets bit 4
// - collision flag set only at 106 kBd, else held zero
// - receive start-up clears collision, crc, parity and protocol flags
// - crc failure with rx crc check enabled sets bit 2
// - parity failure sets bit 1, only at 106 kBd
// - malformed start-of-frame sets bit 0 at 106 kBd
// - byte count mismatch during auth sets protocol flag
// - command start clears all errors except overheat
// - overheat flag cannot be set by software
// - summary error flag high when any error bit set
// - crc done reaches irq pin only with its enable
// - edge flag reaches irq pin only with its enable
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "irq_flags_consts.vh"
module irq_and_error_flags #(
   parameter AW = 8
) (
   input wire ref_clk,
   input wire nrst,
   input wire [AW-1:0] regAddr,
   input wire [7:0] regWdata,
   input wire regWr,
   input wire regRd,
   output reg [7:0] regRdata,
   input wire auxSerialInput,
   input wire crcComputeDone,
   input wire crcComputeActive,
   input wire hostFifoWrite,
   input wire cardAuthActive,
   input wire rfTurnaround,
   input wire overheatDetect,
   input wire overheatClear,
   input wire fifoWriteWhileFull,
   input wire collisionDetect,
   input wire anticollActive,
   input wire crcFail,
   input wire parityFail,
   input wire frameStartBad,
   input wire authByteCountBad,
   input wire rxStartup,
   input wire commandStart,
   output reg antennaEnable,
   output reg anyErrorIrqFlag,
   output reg irqOut
);
   // ****************************************
   // decode and software strobes
   // ****************************************
   reg [7:0] ienQ;
   reg [7:0] cfgQ;
   wire [7:0] auxFlags;
   wire [7:0] errFlags;
   wire edgePulse;
   wire wrAux = regWr && (regAddr == `ADDR_AUX_IRQ_FLAGS);
   wire wrSet = wrAux && regWdata[`AUX_SET_CLEAR_BIT];
   wire wrClr = wrAux && !regWdata[`AUX_SET_CLEAR_BIT];
   wire rxCrcCheckEnable = cfgQ[`CFG_RX_CRC_EN_BIT];
   wire at106 = (cfgQ[`CFG_RATE_LSB+1:`CFG_RATE_LSB] == `RATE_106);

   // ****************************************
   // aux serial input edge detect
   // ****************************************
   edge_sync uEdge (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .pinIn(auxSerialInput),
      .edgePulse(edgePulse)
   );

   // ****************************************
   // aux interrupt flags
   // ****************************************
   // only marked bits move; zero bits keep state
   sticky_flag uEdgeFlag (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .hwSet(edgePulse),
      .hwClr(1'b0),
      .swSet(wrSet && regWdata[`AUX_EDGE_BIT]),
      .swClr(wrClr && regWdata[`AUX_EDGE_BIT]),
      .flag(auxFlags[`AUX_EDGE_BIT])
   );
   sticky_flag uCrcFlag (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .hwSet(crcComputeDone && crcComputeActive),
      .hwClr(1'b0),
      .swSet(wrSet && regWdata[`AUX_CRC_BIT]),
      .swClr(wrClr && regWdata[`AUX_CRC_BIT]),
      .flag(auxFlags[`AUX_CRC_BIT])
   );
   // reserved positions tie to zero; and
   assign auxFlags[7:5] = 3'h0;
   assign auxFlags[3] = 1'b0;
   assign auxFlags[1:0] = 2'h0;

   // ****************************************
   // command error flags
   // ****************************************
   // no software write path at all
   wire rxClr = rxStartup || commandStart;
   sticky_flag uMisuse (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .hwSet(hostFifoWrite && (cardAuthActive || rfTurnaround)),
      .hwClr(commandStart),
      .swSet(1'b0),
      .swClr(1'b0),
      .flag(errFlags[`ERR_WRITE_MISUSE_BIT])
   );
   // overheat survives command start; only the sensor clear drops it
   sticky_flag uHeat (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .hwSet(overheatDetect),
      .hwClr(overheatClear),
      .swSet(1'b0),
      .swClr(1'b0),
      .flag(errFlags[`ERR_OVERHEAT_BIT])
   );
   sticky_flag uOvfl (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .hwSet(fifoWriteWhileFull),
      .hwClr(commandStart),
      .swSet(1'b0),
      .swClr(1'b0),
      .flag(errFlags[`ERR_OVERFLOW_BIT])
   );
   sticky_flag uColl (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .hwSet(collisionDetect && anticollActive && at106),
      .hwClr(rxClr || !at106), // held zero off 106 kBd
      .swSet(1'b0),
      .swClr(1'b0),
      .flag(errFlags[`ERR_COLLISION_BIT])
   );
   sticky_flag uCrcErr (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .hwSet(crcFail && rxCrcCheckEnable),
      .hwClr(rxClr),
      .swSet(1'b0),
      .swClr(1'b0),
      .flag(errFlags[`ERR_CRC_BIT])
   );
   sticky_flag uParity (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .hwSet(parityFail && at106),
      .hwClr(rxClr),
      .swSet(1'b0),
      .swClr(1'b0),
      .flag(errFlags[`ERR_PARITY_BIT])
   );
   sticky_flag uProto (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .hwSet((frameStartBad && at106) || (authByteCountBad && cardAuthActive)),
      .hwClr(rxClr),
      .swSet(1'b0),
      .swClr(1'b0),
      .flag(errFlags[`ERR_FRAME_START_BIT])
   );
   assign errFlags[5] = 1'b0;

   // ****************************************
   // control registers
   // ****************************************
   // only enable bits 4 and 2 are stored; others read zero
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ienQ <= `IEN_RESET;
         cfgQ <= `CFG_RESET;
      end else begin
         if (regWr && (regAddr == `ADDR_IRQ_ENABLE)) begin
            ienQ <= regWdata & 8'h14;
         end
         if (regWr && (regAddr == `ADDR_RX_CONFIG)) begin
            cfgQ <= regWdata & 8'h07;
         end
      end
   end

   // ****************************************
   // outputs and read port
   // ****************************************
   // registered so outputs come straight from flops, one cycle late
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         antennaEnable <= 1'b0;
         anyErrorIrqFlag <= 1'b0;
         irqOut <= 1'b0;
         regRdata <= 8'h00;
      end else begin
         antennaEnable <= !errFlags[`ERR_OVERHEAT_BIT];
         anyErrorIrqFlag <= |errFlags;
         irqOut <= (auxFlags[`AUX_CRC_BIT] && ienQ[`AUX_CRC_BIT])
            || (auxFlags[`AUX_EDGE_BIT] && ienQ[`AUX_EDGE_BIT]);
         if (!regRd) begin
            regRdata <= 8'h00;
         end else if (regAddr == `ADDR_AUX_IRQ_FLAGS) begin
            regRdata <= auxFlags;
         end else if (regAddr == `ADDR_CMD_ERROR_FLAGS) begin
            regRdata <= errFlags;
         end else if (regAddr == `ADDR_IRQ_ENABLE) begin
            regRdata <= ienQ;
         end else if (regAddr == `ADDR_RX_CONFIG) begin
            regRdata <= cfgQ;
         end else if (regAddr == `ADDR_STATUS_OUT) begin
            regRdata <= {5'h00, irqOut, anyErrorIrqFlag, antennaEnable};
         end else begin
            regRdata <= 8'h00; // unmapped reads zero
         end
      end
   end
endmodule // irq_and_error_flags

// ---- verif/irq_flags_monitor.sv ----
// checker for the flag block, built on its top-level ports only
// assumes a bind from the bench, one clock ref_clk and async nrst
`timescale 1ns/1ps
module irq_flags_monitor (
   input logic ref_clk,
   input logic nrst,
   input logic [7:0] regAddr,
   input logic [7:0] regWdata,
   input logic regWr,
   input logic regRd,
   input logic [7:0] regRdata,
   input logic crcComputeDone,
   input logic crcComputeActive,
   input logic hostFifoWrite,
   input logic cardAuthActive,
   input logic rfTurnaround,
   input logic overheatDetect,
   input logic overheatClear,
   input logic fifoWriteWhileFull,
   input logic authByteCountBad,
   input logic commandStart,
   input logic antennaEnable,
   input logic anyErrorIrqFlag,
   input logic irqOut
);
   // ************
   // shadow state
   // ************
   logic [7:0] ienQ;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // enable shadow, since the ports cannot show it
   always_ff @(posedge ref_clk or negedge nrst)
      if (!nrst) ienQ <= 8'h00;
      else if (regWr && regAddr == 8'h03) ienQ <= regWdata;
   property p_rdIdle; !regRd |=> regRdata == 8'h00; endproperty
   a_rdIdle: assert property (p_rdIdle) else $error("read data outside read slot");
   property p_rsvd; regRd && regAddr == 8'h05 |=> (regRdata & 8'hEB) == 8'h00; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved aux bits not zero");
   property p_misuse; hostFifoWrite && (cardAuthActive || rfTurnaround) |-> ##2 anyErrorIrqFlag; endproperty
   a_misuse: assert property (p_misuse) else $error("fifo misuse not flagged");
   property p_ovfl; fifoWriteWhileFull |-> ##2 anyErrorIrqFlag; endproperty
   a_ovfl: assert property (p_ovfl) else $error("overflow not flagged");
   property p_auth; authByteCountBad && cardAuthActive |-> ##2 anyErrorIrqFlag; endproperty
   a_auth: assert property (p_auth) else $error("byte count error not flagged");
   property p_heat; overheatDetect |-> ##2 !antennaEnable; endproperty
   a_heat: assert property (p_heat) else $error("antenna left on when hot");
   // overheat must survive a command start
   property p_keep; overheatDetect ##1 (commandStart && !overheatClear) |-> ##2 anyErrorIrqFlag && !antennaEnable;
   endproperty
   a_keep: assert property (p_keep) else $error("overheat lost at command start");
   property p_irqSet; regWr && regAddr == 8'h05 && regWdata[7] && regWdata[2] && ienQ[2] |-> ##2 irqOut; endproperty
   a_irqSet: assert property (p_irqSet) else $error("software set gave no irq");
   property p_crc_done_flag; crcComputeDone && crcComputeActive && ienQ[2] && !regWr |-> ##2 irqOut; endproperty
   a_crc_done_flag: assert property (p_crc_done_flag) else $error("crc done gave no irq");
   property p_mask; irqOut |-> ($past(ienQ) & 8'h14) != 8'h00; endproperty
   a_mask: assert property (p_mask) else $error("irq with sources disabled");
   c_crc: cover property (crcComputeDone && crcComputeActive && ienQ[2]);
   c_keep: cover property (overheatDetect ##1 commandStart);
   c_irq: cover property (irqOut && !ienQ[4]);
endmodule // irq_flags_monitor

// ---- verif/irq_and_error_flags_tb.sv ----
// self-checking bench for the flag block
// assumes the design and checker compiled ahead of this file
`timescale 1ns/1ps
module irq_and_error_flags_tb;
   logic ref_clk = 0, nrst = 0, regWr = 0, regRd = 0, auxSerialInput = 0;
   logic [7:0] regAddr = 8'h00, regWdata = 8'h00, ev = 8'h00;
   logic [3:0] lv = 4'h0, ctl = 4'h0;
   logic [19:0] r;
   wire [7:0] regRdata;
   wire antennaEnable, anyErrorIrqFlag, irqOut, crcComputeDone, rxStartup, commandStart, overheatClear;
   wire crcComputeActive, cardAuthActive, rfTurnaround, anticollActive;
   wire hostFifoWrite, overheatDetect, fifoWriteWhileFull, collisionDetect, crcFail, parityFail;
   wire frameStartBad, authByteCountBad;
   int miscompares = 0, check_count = 0, i;
   // rows: levels, event pulses, expected error register
   logic [19:0] rows [12] = '{20'h48080, 20'h28080, 20'h08000, 20'h04040, 20'h02010, 20'h11008,
      20'h01000, 20'h00804, 20'h00402, 20'h00201, 20'h40101, 20'h00100};
   assign {hostFifoWrite, overheatDetect, fifoWriteWhileFull, collisionDetect} = ev[7:4];
   assign {crcFail, parityFail, frameStartBad, authByteCountBad} = ev[3:0];
   assign {crcComputeActive, cardAuthActive, rfTurnaround, anticollActive} = lv;
   assign {crcComputeDone, rxStartup, commandStart, overheatClear} = ctl;
   irq_and_error_flags dut_u (.*);
   always #12.5 ref_clk = ~ref_clk;
   // *************
   // driver tasks
   // *************
   task chk(input [7:0] g, e);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task close_out;
      if (miscompares == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task wr(input [7:0] a, d);
      regAddr <= a; regWdata <= d; regWr <= 1;
      @(posedge ref_clk) regWr <= 0;
      // one idle edge so a following write never reassigns the strobe in this step
      @(posedge ref_clk);
   endtask
   // data stands only in the cycle after the strobe
   task rd(input [7:0] a, e);
      regAddr <= a; regRd <= 1;
      @(posedge ref_clk) regRd <= 0;
      #1 chk(regRdata, e);
   endtask
   task ps(input [3:0] l, input [7:0] e, input [3:0] c);
      lv <= l; ev <= e; ctl <= c;
      @(posedge ref_clk) ev <= 0;
      ctl <= 0;
      // pulses drop for one edge before the next call may raise them
      @(posedge ref_clk);
   endtask
   // hang guard, counted as a mismatch
   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      close_out;
   end
   // *************
   // main sequence
   // *************
   initial begin
      repeat (16) @(posedge ref_clk);
      nrst <= 1;
      @(posedge ref_clk);
      wr(8'h10, 8'h01);
      for (i = 0; i < 12; i++) begin
         r = rows[i];
         ps(4'h0, 8'h00, 4'h3);
         ps(r[19:16], r[15:8], 4'h0);
         ps(4'h0, 8'h00, 4'h0);
         #1 chk({anyErrorIrqFlag, antennaEnable}, {|r[7:0], ~r[6]});
         rd(8'h06, r[7:0]);
      end
      wr(8'h03, 8'h14);
      ps(4'h0, 8'h00, 4'h8);
      rd(8'h05, 8'h00);
      ps(4'h8, 8'h00, 4'h8);
      rd(8'h05, 8'h04);
      chk(irqOut, 1);
      wr(8'h05, 8'h94);
      rd(8'h05, 8'h14);
      wr(8'h05, 8'h00);
      rd(8'h05, 8'h14);
      wr(8'h05, 8'h04);
      rd(8'h05, 8'h10);
      wr(8'h05, 8'hFF);
      rd(8'h05, 8'h14);
      wr(8'h03, 8'h10);
      wr(8'h05, 8'h10);
      rd(8'h05, 8'h04);
      chk(irqOut, 0);
      wr(8'h05, 8'h04);
      // both pin edges, waiting out the synchroniser
      auxSerialInput <= 1;
      repeat (5) @(posedge ref_clk);
      rd(8'h05, 8'h10);
      chk(irqOut, 1);
      wr(8'h05, 8'h10);
      auxSerialInput <= 0;
      repeat (5) @(posedge ref_clk);
      rd(8'h05, 8'h10);
      ps(4'h5, 8'hBE, 4'h0);
      ps(4'h0, 8'h00, 4'h4);
      rd(8'h06, 8'h90);
      ps(4'h0, 8'h40, 4'h0);
      ps(4'h0, 8'h00, 4'h2);
      rd(8'h06, 8'h40);
      ps(4'h0, 8'h00, 4'h1);
      wr(8'h06, 8'hFF);
      rd(8'h06, 8'h00);
      chk(antennaEnable, 1);
      // slower rate and crc check off: none of these may flag
      wr(8'h10, 8'h02);
      ps(4'h1, 8'h1E, 4'h0);
      ps(4'h0, 8'h00, 4'h0);
      rd(8'h06, 8'h00);
      ps(4'h0, 8'h20, 4'h0);
      wr(8'h05, 8'h84);
      nrst <= 0;
      repeat (16) @(posedge ref_clk);
      nrst <= 1;
      @(posedge ref_clk);
      rd(8'h06, 8'h00);
      rd(8'h05, 8'h00);
      rd(8'h03, 8'h00);
      rd(8'h3F, 8'h00);
      close_out;
   end
endmodule // irq_and_error_flags_tb
bind irq_and_error_flags irq_flags_monitor mon_u (.*);
